// ---- hdl/esc_regs.vh ----
// Register offsets, field positions and timing counts of the sample capture unit
`ifndef ESC_REGS_VH
`define ESC_REGS_VH
`define ESC_REG_CTRL      8'h00
`define ESC_REG_STATUS    8'h04
`define ESC_REG_MASK      8'h08
`define ESC_REG_TRIGIDX   8'h0c
`define ESC_REG_RDADDR    8'h10
`define ESC_REG_RDDATA    8'h14
`define ESC_REG_RDSTAMP   8'h18
`define ESC_REG_WP_BASE   8'h20
`define ESC_WP_STRIDE     8'h10
`define ESC_WP_ARMEN      8'h00
`define ESC_WP_VALUE      8'h04
`define ESC_WP_FROM       8'h08
`define ESC_WP_ID         8'h0c
`define ESC_CTRL_START    0
`define ESC_CTRL_STOP     1
`define ESC_CTRL_COMP     2
`define ESC_CTRL_POS_LO   3
`define ESC_CTRL_POS_HI   4
`define ESC_CTRL_NOCOMP   5
`define ESC_WP_ACTIVE     0
`define ESC_WP_TRANS      1
`define ESC_POS_EARLY     2'h0
`define ESC_POS_MIDDLE    2'h1
`define ESC_POS_LATE      2'h2
`define ESC_COMP_RUN      7'h40
`define ESC_ADDR_BITS     6
`define ESC_DEPTH         64
`define ESC_DATA_BITS     16
`define ESC_NUM_WP        2
`endif

// ---- hdl/esc_capture.v ----
// Embedded sample capture unit: watchpoints, circular buffer, compression, Wishbone slave
`timescale 1ns/100ps
`include "esc_regs.vh"
module esc_capture (
    input  wire        clk,
    input  wire        reset,
    input  wire [15:0] probe,
    input  wire [1:0]  bkpt,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_stb_i,
    input  wire        wb_cyc_i,
    output reg         wb_ack_o,
    output reg         capture_busy,
    output reg         capture_done
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_POST  = 2'h2;
    localparam ST_DONE  = 2'h3;

    // Watchpoint register addresses: one stride per replicated instance
    localparam [7:0] WP0_ARM   = `ESC_REG_WP_BASE + `ESC_WP_ARMEN;
    localparam [7:0] WP0_VALUE = `ESC_REG_WP_BASE + `ESC_WP_VALUE;
    localparam [7:0] WP0_FROM  = `ESC_REG_WP_BASE + `ESC_WP_FROM;
    localparam [7:0] WP1_ARM   = `ESC_REG_WP_BASE + `ESC_WP_STRIDE + `ESC_WP_ARMEN;
    localparam [7:0] WP1_VALUE = `ESC_REG_WP_BASE + `ESC_WP_STRIDE + `ESC_WP_VALUE;
    localparam [7:0] WP1_FROM  = `ESC_REG_WP_BASE + `ESC_WP_STRIDE + `ESC_WP_FROM;

    // Probe and breakpoint pins come from foreign logic: two-flop sync
    reg [15:0] probe_s1;
    reg [15:0] probe_s2;
    reg [1:0]  bkpt_s1;
    reg [1:0]  bkpt_s2;
    always @(posedge clk) begin
        probe_s1 <= probe;
        probe_s2 <= probe_s1;
        bkpt_s1  <= bkpt;
        bkpt_s2  <= bkpt_s1;
    end

    // Control registers
    reg [1:0]  state;
    reg        comp_en;
    reg        force_full;
    reg [1:0]  trig_pos;
    reg [15:0] comp_mask;
    reg [1:0]  wp_ctl0;
    reg [1:0]  wp_ctl1;
    reg [15:0] wp_val0;
    reg [15:0] wp_val1;
    reg [15:0] wp_from0;
    reg [15:0] wp_from1;
    reg [1:0]  bk_arm;
    reg [5:0]  rd_addr;
    reg [15:0] prev_probe;

    // Buffer and stamps: each entry stores data and its cycle offset from arming
    reg [15:0] buf_data  [0:`ESC_DEPTH-1];
    reg [15:0] buf_stamp [0:`ESC_DEPTH-1];
    reg [5:0]  wr_ptr;
    reg [6:0]  fill;
    reg [5:0]  post_left;
    reg [15:0] cyc_cnt;
    reg [15:0] trig_cyc;
    reg [5:0]  trig_slot;
    reg [6:0]  same_run;

    wire acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_acc = acc & wb_we_i & wb_sel_i[0];
    // Control strobes decoded once so sequencer and settings agree
    wire ctrl_wr   = wr_acc & (wb_adr_i == `ESC_REG_CTRL);
    wire start_req = ctrl_wr & wb_dat_i[`ESC_CTRL_START];
    wire stop_req  = ctrl_wr & wb_dat_i[`ESC_CTRL_STOP];

    // Watchpoint and breakpoint matching, one unit per replicated instance
    wire wp_fire0;
    wire wp_fire1;
    esc_wp_match wp_unit0 (
        .now_val   (probe_s2),
        .last_val  (prev_probe),
        .match_val (wp_val0),
        .from_val  (wp_from0),
        .ctl       (wp_ctl0),
        .bk_armed  (bk_arm[0]),
        .bk_hit    (bkpt_s2[0]),
        .fire      (wp_fire0)
    );

    esc_wp_match wp_unit1 (
        .now_val   (probe_s2),
        .last_val  (prev_probe),
        .match_val (wp_val1),
        .from_val  (wp_from1),
        .ctl       (wp_ctl1),
        .bk_armed  (bk_arm[1]),
        .bk_hit    (bkpt_s2[1]),
        .fire      (wp_fire1)
    );
    wire trigger  = (state == ST_ARMED) & (wp_fire0 | wp_fire1);

    // Change detection ignores masked bits
    wire changed  = |((probe_s2 ^ prev_probe) & ~comp_mask);
    wire comp_on  = comp_en & ~force_full;
    wire run_full = (same_run == `ESC_COMP_RUN - 7'h01);
    wire keep     = ~comp_on | changed | run_full | trigger | (fill == 7'h00);
    wire sampling = (state == ST_ARMED) | (state == ST_POST);
    wire do_write = sampling & keep;

    // Samples kept after the trigger for each position
    reg [5:0] post_count;
    always @* begin
        // Late keeps the fewest samples after the trigger, early the most
        case (trig_pos)
            `ESC_POS_EARLY:  post_count = 6'h30;
            `ESC_POS_MIDDLE: post_count = 6'h20;
            `ESC_POS_LATE:   post_count = 6'h0f;
            default:         post_count = 6'h20;
        endcase
    end

    // Capture sequencer
    always @(posedge clk) begin
        if (reset) begin
            state      <= ST_IDLE;
            wr_ptr     <= 6'h00;
            fill       <= 7'h00;
            post_left  <= 6'h00;
            cyc_cnt    <= 16'h0000;
            trig_cyc   <= 16'h0000;
            trig_slot  <= 6'h00;
            same_run   <= 7'h00;
            prev_probe <= 16'h0000;
        end else begin
            prev_probe <= probe_s2;
            if (sampling) begin
                cyc_cnt <= cyc_cnt + 16'h0001;
            end
            // Count unchanged cycles since last stored sample
            if (do_write) begin
                same_run <= 7'h00;
            end else if (sampling) begin
                same_run <= same_run + 7'h01;
            end
            // Stamps are 16 bits wide: runs beyond 65536 cycles wrap the offsets
            if (do_write) begin
                buf_data[wr_ptr]  <= probe_s2;
                buf_stamp[wr_ptr] <= cyc_cnt;
                wr_ptr            <= wr_ptr + 6'h01;
                if (fill != 7'h40) begin
                    fill <= fill + 7'h01;
                end
            end
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state    <= ST_ARMED;
                        wr_ptr   <= 6'h00;
                        fill     <= 7'h00;
                        cyc_cnt  <= 16'h0000;
                        same_run <= 7'h00;
                    end
                end
                ST_ARMED: begin
                    if (trigger) begin
                        state     <= ST_POST;
                        trig_cyc  <= cyc_cnt;
                        trig_slot <= wr_ptr;
                        post_left <= post_count;
                    end
                end
                ST_POST: begin
                    if (do_write) begin
                        if (post_left == 6'h00) begin
                            state <= ST_DONE;
                        end else begin
                            post_left <= post_left - 6'h01;
                        end
                    end
                end
                ST_DONE: begin
                    if (start_req) begin
                        state    <= ST_ARMED;
                        wr_ptr   <= 6'h00;
                        fill     <= 7'h00;
                        cyc_cnt  <= 16'h0000;
                        same_run <= 7'h00;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Stop is applied last so it overrides an arm or trigger in this cycle
            if (stop_req) begin
                state <= ST_IDLE;
            end
        end
    end

    // Settings writes; mode bits are refused while a run is active
    always @(posedge clk) begin
        if (reset) begin
            comp_en    <= 1'b0;
            force_full <= 1'b0;
            trig_pos   <= `ESC_POS_MIDDLE;
            comp_mask  <= 16'h0000;
            wp_ctl0    <= 2'h0;
            wp_ctl1    <= 2'h0;
            wp_val0    <= 16'h0000;
            wp_val1    <= 16'h0000;
            wp_from0   <= 16'h0000;
            wp_from1   <= 16'h0000;
            bk_arm     <= 2'h0;
            rd_addr    <= 6'h00;
        end else if (wr_acc) begin
            case (wb_adr_i)
                `ESC_REG_CTRL: begin
                    if (!sampling) begin
                        comp_en    <= wb_dat_i[`ESC_CTRL_COMP];
                        trig_pos   <= wb_dat_i[`ESC_CTRL_POS_HI:`ESC_CTRL_POS_LO];
                        force_full <= wb_dat_i[`ESC_CTRL_NOCOMP];
                    end
                end
                `ESC_REG_MASK:   comp_mask <= wb_dat_i[15:0];
                `ESC_REG_RDADDR: rd_addr   <= wb_dat_i[5:0];
                WP0_ARM: begin
                    wp_ctl0   <= wb_dat_i[1:0];
                    bk_arm[0] <= wb_dat_i[2];
                end
                WP0_VALUE: wp_val0  <= wb_dat_i[15:0];
                WP0_FROM:  wp_from0 <= wb_dat_i[15:0];
                WP1_ARM: begin
                    wp_ctl1   <= wb_dat_i[1:0];
                    bk_arm[1] <= wb_dat_i[2];
                end
                WP1_VALUE: wp_val1  <= wb_dat_i[15:0];
                WP1_FROM:  wp_from1 <= wb_dat_i[15:0];
                // Unmapped writes are acknowledged but change no setting
                default:   rd_addr <= rd_addr;
            endcase
        end
    end

    // Readout slot counts from oldest stored entry
    // Until the buffer has wrapped, the oldest entry sits in slot zero
    wire [5:0]  oldest   = (fill == 7'h40) ? wr_ptr : 6'h00;
    wire [5:0]  rd_slot  = oldest + rd_addr;
    wire [15:0] rel_cyc  = buf_stamp[rd_slot] - trig_cyc;
    wire [5:0]  trig_rel = trig_slot - oldest;

    // Read mux: unmapped addresses read as zero
    reg [31:0] next_dat_o;
    always @* begin
        case (wb_adr_i)
            `ESC_REG_CTRL:    next_dat_o = {26'h0, force_full, trig_pos, comp_en, 2'h0};
            `ESC_REG_STATUS:  next_dat_o = {23'h0, fill, state};
            `ESC_REG_MASK:    next_dat_o = {16'h0, comp_mask};
            `ESC_REG_TRIGIDX: next_dat_o = {26'h0, trig_rel};
            `ESC_REG_RDADDR:  next_dat_o = {26'h0, rd_addr};
            `ESC_REG_RDDATA:  next_dat_o = {16'h0, buf_data[rd_slot]};
            `ESC_REG_RDSTAMP: next_dat_o = {16'h0, rel_cyc};
            WP0_ARM:          next_dat_o = {29'h0, bk_arm[0], wp_ctl0};
            WP0_VALUE:        next_dat_o = {16'h0, wp_val0};
            WP0_FROM:         next_dat_o = {16'h0, wp_from0};
            WP1_ARM:          next_dat_o = {29'h0, bk_arm[1], wp_ctl1};
            WP1_VALUE:        next_dat_o = {16'h0, wp_val1};
            WP1_FROM:         next_dat_o = {16'h0, wp_from1};
            default:          next_dat_o = 32'h00000000;
        endcase
    end

    // Wishbone slave: ack one cycle after strobe
    always @(posedge clk) begin
        if (reset) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h00000000;
            capture_busy <= 1'b0;
            capture_done <= 1'b0;
        end else begin
            wb_ack_o     <= acc;
            capture_busy <= sampling;
            capture_done <= (state == ST_DONE);
            // Registered so read data stands with ack for exactly one cycle
            wb_dat_o     <= next_dat_o;
        end
    end
endmodule

// One watchpoint and its breakpoint: each replicated instance has its own arm bits
module esc_wp_match (
    input  wire [15:0] now_val,
    input  wire [15:0] last_val,
    input  wire [15:0] match_val,
    input  wire [15:0] from_val,
    input  wire [1:0]  ctl,
    input  wire        bk_armed,
    input  wire        bk_hit,
    output wire        fire
);
    // Value hit compares the current sample; transition also checks the one before
    wire val_hit = (now_val == match_val);
    wire tr_hit  = val_hit & (last_val == from_val);
    // A deactivated watchpoint keeps its values but never fires
    wire wp_hit  = ctl[`ESC_WP_ACTIVE] & (ctl[`ESC_WP_TRANS] ? tr_hit : val_hit);
    // Breakpoint level counts only while its own arm bit is set
    assign fire = wp_hit | (bk_armed & bk_hit);
endmodule

// ---- test/esc_probe_src.sv ----
// Model of the instrumented design: counting probe bus and breakpoint levels
`timescale 1ns/100ps
module esc_probe_src (
    input  wire        clk,
    input  wire        load,
    input  wire [15:0] base,
    output reg  [15:0] probe,
    output wire [1:0]  bkpt
);
    initial probe = 16'h0000;
    // Counts every clock while load is low, so no two neighbouring samples are alike
    always @(posedge clk) begin
        probe <= load ? base : probe + 16'h0001;
    end
    // Branches taken at fixed values; they only matter where armed
    assign bkpt = {probe[7:0] == 8'hf0, probe[7:0] == 8'h0f};
endmodule

// ---- test/esc_capture_chk.sv ----
// Port-level checker for the sample capture unit
`timescale 1ns/100ps
module esc_capture_chk (
    input wire        clk,
    input wire        reset,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_we_i,
    input wire [3:0]  wb_sel_i,
    input wire        wb_stb_i,
    input wire        wb_cyc_i,
    input wire        wb_ack_o,
    input wire        capture_busy,
    input wire        capture_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Taken request, taken control write, taken unmapped read
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ctl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
    wire rdu = req && !wb_we_i && wb_adr_i == 8'hfc;
    sequence s_take; req; endsequence
    sequence s_answer; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_walk: assert property (s_take |-> s_answer)
        else $error("ack timing wrong");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (rdu |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_busy_done_excl: assert property (!(capture_busy && capture_done))
        else $error("busy and done together");
    a_start_arms: assert property (ctl && wb_dat_i[0] |-> ##[1:2] capture_busy)
        else $error("start did not arm");
    a_stop_idles: assert property (ctl && wb_dat_i[1] |-> ##2 !capture_busy && !capture_done)
        else $error("stop did not idle");
    a_done_after_busy: assert property ($rose(capture_done) |-> $past(capture_busy))
        else $error("done without run");
    a_done_cause: assert property ($fell(capture_done) |->
        $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
        else $error("done cleared without write");
endmodule

// ---- test/test_embedded_sample_capture.sv ----
// Self-checking bench for the sample capture unit
`timescale 1ns/100ps
module test_embedded_sample_capture;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] wdat = 32'h0;
    reg         we = 1'b0;
    reg         stb = 1'b0;
    reg  [3:0]  sel = 4'hf;
    reg         load = 1'b1;
    reg  [15:0] base = 16'h0000;
    wire [15:0] probe;
    wire [1:0]  bkpt;
    wire [31:0] rdat;
    wire        ack, busy, done;
    integer     fail_count = 0;
    integer     checks_done = 0;
    integer     seed = 32'h3b16;
    reg  [31:0] got, e, m;
    reg  [31:0] exp_q[$], msk_q[$];
    reg  [15:0] v;
    reg  [7:0]  t;
    reg  [7:0]  tp[0:2];
    reg  [1:0]  p;
    always #50 clk = ~clk;
    esc_capture dut (.clk(clk), .reset(reset), .probe(probe), .bkpt(bkpt), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb),
        .wb_cyc_i(stb), .wb_ack_o(ack), .capture_busy(busy), .capture_done(done));
    esc_probe_src src (.clk(clk), .load(load), .base(base), .probe(probe), .bkpt(bkpt));
    task tally_and_finish;
        begin
            $display("Checks %0d, errors %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then one idle cycle
    task bus(input [7:0] a, input w, input [31:0] d);
        integer n;
        begin
            adr <= a;
            we <= w;
            wdat <= d;
            stb <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (ack !== 1'b1 && n < 20);
            got = rdat;
            stb <= 1'b0;
            if (n >= 20) begin
                $display("Error: ack expected 1 seen 0");
                fail_count = fail_count + 1;
                tally_and_finish;
            end
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] ev, input [31:0] mv);
        begin
            exp_q.push_back(ev);
            msk_q.push_back(mv);
            bus(a, 1'b0, 32'h0);
        end
    endtask
    // Read answers are matched against the oldest note; a zero mask only fetches
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 32'h0) begin
                checks_done = checks_done + 1;
                if ((rdat & m) !== (e & m)) begin
                    $display("Error: read %h expected %h seen %h", adr, e & m, rdat & m);
                    fail_count = fail_count + 1;
                end
            end
        end
    end
    // One capture run triggered at probe value v; d is the expected stamp step
    task run(input [1:0] ps, input [31:0] md, input wk, input [15:0] mk, input [15:0] d);
        integer n;
        begin
            e = $random(seed);
            base <= e[15:0];
            v = e[15:0] + 16'h00c8;
            load <= 1'b1;
            bus(8'h08, 1'b1, {16'h0, mk});
            load <= 1'b0;
            bus(8'h20, 1'b1, 32'h0);
            bus(8'h30, 1'b1, 32'h0);
            bus(8'h24 + {wk, 4'h0}, 1'b1, {16'h0, v});
            bus(8'h28 + {wk, 4'h0}, 1'b1, {16'h0, v - 16'h1});
            bus(8'h20 + {wk, 4'h0}, 1'b1, {30'h0, wk, 1'b1});
            bus(8'h00, 1'b1, md | {27'h0, ps, 3'h0});
            bus(8'h00, 1'b1, md | {27'h0, ps, 3'h1});
            rd(8'h04, 32'h1, 32'h3);
            n = 0;
            while (done !== 1'b1 && n < 9000) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 9000) begin
                $display("Error: done expected 1 seen 0");
                fail_count = fail_count + 1;
                tally_and_finish;
            end
            rd(8'h0c, 32'h0, 32'h0);
            t = got[7:0];
            bus(8'h10, 1'b1, {24'h0, t});
            rd(8'h18, 32'h0, 32'hffff);
            rd(8'h14, {16'h0, v}, 32'hffffffff);
            bus(8'h10, 1'b1, {24'h0, t + 8'h01});
            rd(8'h18, {16'h0, d}, 32'hffff);
            rd(8'h14, {16'h0, v + d}, 32'hffffffff);
            if (d == 16'h1) begin
                bus(8'h10, 1'b1, {24'h0, t - 8'h01});
                rd(8'h18, 32'hffff, 32'hffff);
                rd(8'h14, {16'h0, v - 16'h1}, 32'hffffffff);
            end
            bus(8'h00, 1'b1, 32'h2);
            rd(8'h04, 32'h0, 32'h3);
        end
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(8'h04, 32'h0, 32'hffffffff);
        rd(8'h20, 32'h0, 32'hffffffff);
        bus(8'hfc, 1'b1, 32'hffffffff);
        rd(8'hfc, 32'h0, 32'hffffffff);
        sel <= 4'he;
        bus(8'h08, 1'b1, 32'hffff);
        sel <= 4'hf;
        rd(8'h08, 32'h0, 32'hffffffff);
        for (p = 2'h0; p != 2'h3; p = p + 2'h1) begin
            run(p, 32'h0, 1'b0, 16'h0, 16'h1);
            tp[p] = t;
        end
        checks_done = checks_done + 1;
        if (!(tp[0] < tp[1] && tp[1] < tp[2])) begin
            $display("Error: trigger index order expected rising seen %h %h %h", tp[0], tp[1], tp[2]);
            fail_count = fail_count + 1;
        end
        run(2'h1, 32'h4, 1'b1, 16'hffff, 16'h40);
        run(2'h1, 32'h24, 1'b0, 16'hffff, 16'h1);
        run(2'h1, 32'h4, 1'b0, 16'h0, 16'h1);
        bus(8'h20, 1'b0 | 1'b1, 32'h0);
        bus(8'h00, 1'b1, 32'h1);
        repeat (300) @(posedge clk);
        rd(8'h04, 32'h1, 32'h3);
        rd(8'h24, {16'h0, v}, 32'hffffffff);
        bus(8'h00, 1'b1, 32'h2);
        tally_and_finish;
    end
endmodule
bind esc_capture esc_capture_chk chk (.clk(clk), .reset(reset), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
    .capture_busy(capture_busy), .capture_done(capture_done));
